//--- test/dceic_props.sv
`timescale 1ns/1ps
// ----------
// Port checks of the event and interrupt block.
// ----------
module dceic_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tr_valid,
  input wire logic tr_ready,
  input wire logic [3:0] tr_chan,
  input wire logic tr_queue,
  input wire logic cmpl_valid,
  input wire logic cmpl_int_en,
  input wire logic cmpl_irq,
  input wire logic [1:0] region_irq
);
  logic wr_acc;
  logic setup;
  assign wr_acc = psel && penable && pwrite && pready;
  assign setup = psel && !penable && pce;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_NEXT: assert property (
    setup |=> pready) else $error("no bus answer after setup");
  AST_READY_PULSE: assert property (
    pready && pce |=> !pready) else $error("bus answer longer than one cycle");
  AST_ERR_QUAL: assert property (
    pslverr |-> pready) else $error("error flag without answer");
  AST_SHADOW_LIM: assert property (
    setup && paddr[11:8] == 4'h1 && paddr[5:0] >= 6'h38 |=> pslverr) else $error("shadow limit not refused");
  AST_IRQ_CLEAR: assert property (
    $fell(cmpl_irq) |-> $past(wr_acc, 2)) else $error("interrupt dropped without a write");
  AST_IRQ_CAUSE: assert property (
    $rose(cmpl_irq) |-> $past(cmpl_valid && cmpl_int_en, 2) || $past(wr_acc, 2) || $past(tr_valid && tr_ready, 2))
    else $error("interrupt rose without a cause");
  AST_REGION_SUB: assert property (
    region_irq != 2'h0 |-> cmpl_irq) else $error("region interrupt without main interrupt");
  AST_TR_HOLD: assert property (
    tr_valid && !tr_ready |=> tr_valid && $stable(tr_chan) && $stable(tr_queue)) else $error("request not held");
endmodule : dceic_props
bind dceic_top dceic_props i_props (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .tr_valid(tr_valid), .tr_ready(tr_ready),
  .tr_chan(tr_chan), .tr_queue(tr_queue), .cmpl_valid(cmpl_valid), .cmpl_int_en(cmpl_int_en),
  .cmpl_irq(cmpl_irq), .region_irq(region_irq));

//--- test/dceic_top_bench.sv
`timescale 1ns/1ps
// ----------
// Bench of the event and interrupt block.
// ----------
module dceic_top_bench;
  logic pclk = 1'b0, presetn = 1'b0, pce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic parameter_ram_wr_valid = 1'b0, chain_on = 1'b0, pready, pslverr, last_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0] periph_evt = 8'h00, stall = 8'h02;
  logic [9:0] parameter_ram_null = 10'h000;
  logic [4:0] parameter_ram_wr_set = 5'h00;
  logic [2:0] parameter_ram_wr_word = 3'h0, chain_code = 3'h0, cmpl_code;
  logic [3:0] tr_chan;
  logic [1:0] region_irq;
  logic cmpl_valid, cmpl_int_en, cmpl_chain_en, tu_busy, tr_valid, tr_queue, tr_ready, cmpl_irq;
  int failures = 0, total_checks = 0, cycles = 0;
  dceic_top i_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_evt(periph_evt),
    .parameter_ram_null(parameter_ram_null), .parameter_ram_wr_valid(parameter_ram_wr_valid), .parameter_ram_wr_set(parameter_ram_wr_set),
    .parameter_ram_wr_word(parameter_ram_wr_word), .cmpl_valid(cmpl_valid), .cmpl_code(cmpl_code), .cmpl_int_en(cmpl_int_en),
    .cmpl_chain_en(cmpl_chain_en), .tu_busy(tu_busy), .tr_valid(tr_valid), .tr_chan(tr_chan), .tr_queue(tr_queue),
    .tr_ready(tr_ready), .cmpl_irq(cmpl_irq), .region_irq(region_irq));
  dceic_xfer_model i_xfer (.pclk(pclk), .presetn(presetn), .tr_valid(tr_valid), .tr_chan(tr_chan), .stall(stall),
    .chain_on(chain_on), .chain_code(chain_code), .tr_ready(tr_ready), .cmpl_valid(cmpl_valid),
    .cmpl_code(cmpl_code), .cmpl_int_en(cmpl_int_en), .cmpl_chain_en(cmpl_chain_en), .tu_busy(tu_busy));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    cmp(r, exp);
  endtask : rd
  task automatic acc(input logic [3:0] ch, input logic q);
    do @(posedge pclk); while (!(tr_valid === 1'b1 && tr_ready === 1'b1));
    cmp({27'h000_0000, tr_queue, tr_chan}, {27'h000_0000, q, ch});
  endtask : acc
  task automatic t_bus;
    rd(12'h000, dceic_pkg::RST_VAL);
    rd(12'h138, 32'h0000_0000);
    cmp({31'h0000_0000, last_err}, 32'h0000_0001);
  endtask : t_bus
  task automatic t_event;
    wr(12'h010, 32'h0000_0004);
    wr(12'h010, 32'h0000_0000);
    rd(12'h00c, 32'h0000_0004);
    wr(12'h038, 32'h0000_0004);
    periph_evt <= 8'h06;
    tick(4);
    periph_evt <= 8'h00;
    acc(4'h2, 1'b1);
    rd(12'h000, 32'h0000_0002);
    wr(12'h000, 32'h0000_00ff);
    rd(12'h000, 32'h0000_0002);
    wr(12'h004, 32'h0000_0002);
    rd(12'h000, 32'h0000_0000);
    rd(12'h090, 32'h0000_0002);
    wr(12'h014, 32'h0000_0004);
    rd(12'h00c, 32'h0000_0000);
  endtask : t_event
  task automatic t_irq;
    wr(12'h048, 32'h0000_0008);
    wr(12'h04c, 32'h0000_0008);
    wr(12'h024, 32'h0000_0008);
    rd(12'h020, 32'h0000_0008);
    wr(12'h008, 32'h0000_0008);
    acc(4'h3, 1'b0);
    tick(6);
    cmp({29'h0000_0000, region_irq, cmpl_irq}, 32'h0000_0007);
    wr(12'h01c, 32'h0000_0000);
    wr(12'h04c, 32'h0000_0000);
    rd(12'h158, 32'h0000_0000);
    rd(12'h118, 32'h0000_0008);
    wr(12'h15c, 32'h0000_0008);
    tick(2);
    cmp({29'h0000_0000, region_irq, cmpl_irq}, 32'h0000_0003);
    wr(12'h11c, 32'h0000_0008);
    tick(2);
    cmp({31'h0000_0000, cmpl_irq}, 32'h0000_0000);
  endtask : t_irq
  task automatic t_chain;
    stall <= 8'h06;
    chain_on <= 1'b1;
    chain_code <= 3'h5;
    wr(12'h008, 32'h0000_0001);
    acc(4'h0, 1'b0);
    tick(4);
    chain_on <= 1'b0;
    acc(4'h5, 1'b0);
    stall <= 8'h02;
  endtask : t_chain
  task automatic t_queued;
    wr(12'h040, 32'h0000_0703);
    rd(12'h040, 32'h0000_0703);
    wr(12'h030, 32'h0000_0001);
    rd(12'h02c, 32'h0000_0001);
    parameter_ram_wr_set <= 5'h03;
    parameter_ram_wr_word <= 3'h2;
    parameter_ram_wr_valid <= 1'b1;
    tick(1);
    parameter_ram_wr_valid <= 1'b0;
    tick(8);
    cmp({31'h0000_0000, tr_valid}, 32'h0000_0000);
    parameter_ram_wr_word <= 3'h7;
    parameter_ram_wr_valid <= 1'b1;
    tick(1);
    parameter_ram_wr_valid <= 1'b0;
    acc(4'h8, 1'b0);
  endtask : t_queued
  task automatic t_null;
    parameter_ram_null <= 10'h080;
    wr(12'h008, 32'h0000_0080);
    tick(6);
    cmp({31'h0000_0000, tr_valid}, 32'h0000_0000);
    rd(12'h058, 32'h0000_0080);
    rd(12'h05c, 32'h0000_0080);
    wr(12'h060, 32'h0000_0080);
    rd(12'h058, 32'h0000_0000);
    parameter_ram_null <= 10'h000;
  endtask : t_null
  task automatic t_early;
    wr(12'h01c, 32'h0000_00ff);
    rd(12'h018, 32'h0000_0000);
    wr(12'h06c, 32'h0000_0010);
    wr(12'h008, 32'h0000_0010);
    acc(4'h4, 1'b0);
    rd(12'h018, 32'h0000_0010);
    tick(8);
    rd(12'h068, 32'h0000_0000);
  endtask : t_early
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_event();
    t_irq();
    t_chain();
    t_queued();
    t_null();
    t_early();
    complete_run();
  end
endmodule : dceic_top_bench

//--- test/dceic_xfer_model.sv
`timescale 1ns/1ps
// ----------
// Transfer unit model.
// ----------
module dceic_xfer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tr_valid,
  input wire logic [3:0] tr_chan,
  input wire logic [7:0] stall,
  input wire logic chain_on,
  input wire logic [2:0] chain_code,
  output logic tr_ready,
  output logic cmpl_valid,
  output logic [2:0] cmpl_code,
  output logic cmpl_int_en,
  output logic cmpl_chain_en,
  output logic tu_busy
);
  logic [7:0] wait_q;
  logic [1:0] run_q;
  logic [3:0] chan_q;
  logic [2:0] code_w;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 8'h00;
      tr_ready <= 1'b0;
    end else if (tr_valid && !tr_ready && !tu_busy) begin
      wait_q <= wait_q + 8'h01;
      tr_ready <= (wait_q >= stall);
    end else begin
      wait_q <= 8'h00;
      tr_ready <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 2'h0;
      chan_q <= 4'h0;
    end else if (tr_valid && tr_ready) begin
      run_q <= 2'h3;
      chan_q <= tr_chan;
    end else if (run_q != 2'h0) begin
      run_q <= run_q - 2'h1;
    end
  end
  assign tu_busy = (run_q != 2'h0);
  assign cmpl_valid = (run_q == 2'h1);
  assign code_w = chain_on ? chain_code : chan_q[2:0];
  assign cmpl_code = cmpl_valid ? code_w : ~code_w;
  assign cmpl_int_en = cmpl_valid | run_q[1];
  assign cmpl_chain_en = cmpl_valid ? chain_on : ~chain_on;
endmodule : dceic_xfer_model

//--- verilog/dceic_pkg.sv
package dceic_pkg;
  localparam int NCH = 8;
  localparam int NQD = 2;
  localparam int NALL = 10;
  localparam int CW = 4;
  localparam int NRG = 2;
  localparam int NEQ = 2;
  localparam int QDEPTH = 4;
  localparam int QPW = 2;
  localparam int SETW = 5;
  localparam int WORDW = 3;
  localparam int CODEW = 3;
  localparam int AW = 12;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam logic [11:0] OFF_EVT_PEND = 12'h000;
  localparam logic [11:0] OFF_EVT_CLR = 12'h004;
  localparam logic [11:0] OFF_EVT_SET = 12'h008;
  localparam logic [11:0] OFF_EVT_EN = 12'h00c;
  localparam logic [11:0] OFF_EVT_EN_SET = 12'h010;
  localparam logic [11:0] OFF_EVT_EN_CLR = 12'h014;
  localparam logic [11:0] OFF_INT_PEND = 12'h018;
  localparam logic [11:0] OFF_INT_CLR = 12'h01c;
  localparam logic [11:0] OFF_INT_EN = 12'h020;
  localparam logic [11:0] OFF_INT_EN_SET = 12'h024;
  localparam logic [11:0] OFF_INT_EN_CLR = 12'h028;
  localparam logic [11:0] OFF_Q_EN = 12'h02c;
  localparam logic [11:0] OFF_Q_EN_SET = 12'h030;
  localparam logic [11:0] OFF_Q_EN_CLR = 12'h034;
  localparam logic [11:0] OFF_SHADOW_LIM = 12'h038;
  localparam logic [11:0] OFF_CH_QSEL = 12'h038;
  localparam logic [11:0] OFF_Q_QSEL = 12'h03c;
  localparam logic [11:0] OFF_Q_MAP = 12'h040;
  localparam logic [11:0] OFF_CH_ACC = 12'h048;
  localparam logic [11:0] OFF_Q_ACC = 12'h050;
  localparam logic [11:0] OFF_MISSED = 12'h058;
  localparam logic [11:0] OFF_SECOND = 12'h05c;
  localparam logic [11:0] OFF_ERR_CLR = 12'h060;
  localparam logic [11:0] OFF_CC_STAT = 12'h064;
  localparam logic [11:0] OFF_TU_STAT = 12'h068;
  localparam logic [11:0] OFF_EARLY = 12'h06c;
  localparam logic [11:0] OFF_HIST = 12'h080;
  localparam int QMAP_SET_LSB = 0;
  localparam int QMAP_WORD_LSB = 8;
  localparam int CCST_Q1_LSB = 4;
  localparam int CCST_ACT_BIT = 8;
  localparam int SHADOW_BIT = 8;
  localparam int REGION_BIT = 6;
  localparam int IDX_BIT = 2;
  localparam int HIST_Q_BIT = 4;
endpackage : dceic_pkg

//--- verilog/dceic_top.sv
`timescale 1ns/1ps
// What this block does
// - Event pending bits clear by writing one to the event clear register or when the event is taken for service.
// - Event enable bits set only by writing one to the enable set register.
// - Event enable bits clear only by writing one to the enable clear register.
// - Shadow region access reaches only channels enabled in that region's access enables.
// - A completion enabled in several regions raises each of those regions' interrupts.
// - Early completion is reported when the request is handed to the transfer unit.
// - Each queued channel map holds its parameter set and trigger word selection.
// - A write to an enabled queued channel's trigger word raises its event.
// - Writing one to the event set register manually triggers that channel.
// - A chained completion code raises a trigger event on that channel.
// - Peripheral pulses are latched; only pulses on enabled channels are serviced.
// - Completion interrupt asserts while an enabled interrupt pending bit is set.
// - Interrupt pending bits stay set until written in the interrupt clear register.
// - Interrupt enable bits are set through the interrupt enable set register.
// - Queued channel enables are set through the queued enable set register.
// - Each event goes to the event queue chosen by its queue select field.
// - Event queue entries stay readable after they are processed.
// - Controller and transfer unit activity are readable as status registers.
// - An event on a null parameter set sets missed and secondary bits.
module dceic_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] periph_evt,
  input wire logic [9:0] parameter_ram_null,
  input wire logic parameter_ram_wr_valid,
  input wire logic [4:0] parameter_ram_wr_set,
  input wire logic [2:0] parameter_ram_wr_word,
  input wire logic cmpl_valid,
  input wire logic [2:0] cmpl_code,
  input wire logic cmpl_int_en,
  input wire logic cmpl_chain_en,
  input wire logic tu_busy,
  output logic tr_valid,
  output logic [3:0] tr_chan,
  output logic tr_queue,
  input wire logic tr_ready,
  output logic cmpl_irq,
  output logic [1:0] region_irq
);
  localparam int NCH = dceic_pkg::NCH;
  localparam int NALL = dceic_pkg::NALL;
  localparam int CW = dceic_pkg::CW;
  localparam int NEQ = dceic_pkg::NEQ;
  localparam int QDEPTH = dceic_pkg::QDEPTH;
  localparam int QPW = dceic_pkg::QPW;

  // ----------------------------------------
  // Register storage.
  // ----------------------------------------
  logic [NCH-1:0] evp_q, mset_q, ipr_q, ier_q, early_q;
  logic [dceic_pkg::NQD-1:0] qev_q;
  logic [NALL-1:0] en_q, qsel_q, emr_q, ser_q;
  logic [dceic_pkg::SETW-1:0] map_set_q [dceic_pkg::NQD];
  logic [dceic_pkg::WORDW-1:0] map_word_q [dceic_pkg::NQD];
  logic [NCH-1:0] region_channel_access_enable_q [dceic_pkg::NRG];
  logic [dceic_pkg::NQD-1:0] region_queued_access_enable_q [dceic_pkg::NRG];
  logic [NCH-1:0] ev_s1_q, ev_s2_q, ev_s3_q, ev_lvl_q;

  // ----------------------------------------
  // Bus decode.
  // ----------------------------------------
  logic shadow, rg, bad, wr;
  logic [11:0] off, base8, base32;
  logic [NALL-1:0] mask, wm;
  logic [31:0] rd_d;

  assign shadow = paddr[dceic_pkg::SHADOW_BIT];
  assign rg = paddr[dceic_pkg::REGION_BIT];
  assign off = shadow ? {6'h00, paddr[5:0]} : paddr;
  assign base8 = {off[11:3], 3'h0};
  assign base32 = {off[11:5], 5'h00};
  assign mask = shadow ? {region_queued_access_enable_q[rg], region_channel_access_enable_q[rg]} : '1;
  assign wm = pwdata[NALL-1:0] & mask;
  assign wr = psel & penable & pready & pwrite & ~bad;

  logic [NCH-1:0] event_clear_reg, event_set_reg, event_enable_set_reg, event_enable_clear_reg, interrupt_clear_reg, interrupt_enable_set_reg, iecr;
  logic [dceic_pkg::NQD-1:0] qesr, qecr, wq;
  logic [NALL-1:0] errclr, wa;

  assign wa = wr ? wm : '0;
  assign wq = wr ? (pwdata[dceic_pkg::NQD-1:0] & mask[NALL-1:NCH]) : '0;
  assign event_clear_reg = (off == dceic_pkg::OFF_EVT_CLR) ? wa[NCH-1:0] : '0;
  assign event_set_reg = (off == dceic_pkg::OFF_EVT_SET) ? wa[NCH-1:0] : '0;
  assign event_enable_set_reg = (off == dceic_pkg::OFF_EVT_EN_SET) ? wa[NCH-1:0] : '0;
  assign event_enable_clear_reg = (off == dceic_pkg::OFF_EVT_EN_CLR) ? wa[NCH-1:0] : '0;
  assign interrupt_clear_reg = (off == dceic_pkg::OFF_INT_CLR) ? wa[NCH-1:0] : '0;
  assign interrupt_enable_set_reg = (off == dceic_pkg::OFF_INT_EN_SET) ? wa[NCH-1:0] : '0;
  assign iecr = (off == dceic_pkg::OFF_INT_EN_CLR) ? wa[NCH-1:0] : '0;
  assign qesr = (off == dceic_pkg::OFF_Q_EN_SET) ? wq : '0;
  assign qecr = (off == dceic_pkg::OFF_Q_EN_CLR) ? wq : '0;
  assign errclr = (wr && off == dceic_pkg::OFF_ERR_CLR) ? pwdata[NALL-1:0] : '0;

  // ----------------------------------------
  // Peripheral event capture.
  // ----------------------------------------
  logic [NCH-1:0] ev_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
      ev_lvl_q <= '0;
    end else if (pce) begin
      ev_s1_q <= periph_evt;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      ev_lvl_q <= (ev_s2_q & ev_s3_q) | (ev_lvl_q & (ev_s2_q ^ ev_s3_q));
    end
  end

  assign ev_pulse = ev_s2_q & ev_s3_q & ~ev_lvl_q;

  // ----------------------------------------
  // Queued channel trigger words.
  // ----------------------------------------
  logic [dceic_pkg::NQD-1:0] qtrig;

  genvar gq;
  generate
    for (gq = 0; gq < dceic_pkg::NQD; gq++) begin : g_qtrig
      assign qtrig[gq] = parameter_ram_wr_valid & en_q[NCH+gq] & (parameter_ram_wr_set == map_set_q[gq]) &
                         (parameter_ram_wr_word == map_word_q[gq]);
    end
  endgenerate

  // ----------------------------------------
  // Prioritisation and queueing.
  // ----------------------------------------
  function automatic logic [CW:0] pick(input logic [NALL-1:0] v);
    logic [CW:0] r;
    r = '0;
    for (int i = NALL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, CW'(i)};
      end
    end
    return r;
  endfunction : pick

  logic [NALL-1:0] req;
  logic [CW:0] sel;
  logic [CW-1:0] sch;
  logic sq;
  logic [NEQ-1:0] full, empty;
  logic push, dead, launch, lq, acc;
  logic [NALL-1:0] used;
  logic [QPW:0] wp_q [NEQ], rp_q [NEQ];
  logic [CW-1:0] qmem_q [NEQ][QDEPTH];
  logic [QPW:0] cnt [NEQ];

  assign req = {qev_q, (evp_q & en_q[NCH-1:0]) | mset_q} & ~ser_q;
  assign sel = pick(req);
  assign sch = sel[CW-1:0];
  assign sq = qsel_q[sch];
  assign dead = sel[CW] & parameter_ram_null[sch];
  assign push = sel[CW] & ~parameter_ram_null[sch] & ~full[sq];
  assign used = (dead | push) ? (NALL'(1) << sch) : '0;

  genvar ge;
  generate
    for (ge = 0; ge < NEQ; ge++) begin : g_queue
      logic pop;
      assign pop = launch & (lq == ge);
      assign cnt[ge] = wp_q[ge] - rp_q[ge];
      assign empty[ge] = (wp_q[ge] == rp_q[ge]);
      assign full[ge] = (cnt[ge] == (QPW+1)'(QDEPTH));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wp_q[ge] <= '0;
          rp_q[ge] <= '0;
          for (int e = 0; e < QDEPTH; e++) begin
            qmem_q[ge][e] <= '0;
          end
        end else if (pce) begin
          if (push && sq == ge) begin
            qmem_q[ge][wp_q[ge][QPW-1:0]] <= sch;
            wp_q[ge] <= wp_q[ge] + 1'b1;
          end
          if (pop) begin
            rp_q[ge] <= rp_q[ge] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Hand-off to the transfer unit.
  // ----------------------------------------
  logic [NCH-1:0] early_set;

  assign lq = empty[0];
  assign launch = (~tr_valid | tr_ready) & ~(&empty);
  assign acc = tr_valid & tr_ready;
  assign early_set = (acc & ~tr_chan[CW-1]) ? (early_q & (NCH'(1) << tr_chan[CW-2:0])) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_valid <= 1'b0;
      tr_chan <= '0;
      tr_queue <= 1'b0;
    end else if (pce) begin
      if (launch) begin
        tr_valid <= 1'b1;
        tr_chan <= qmem_q[lq][rp_q[lq][QPW-1:0]];
        tr_queue <= lq;
      end else if (tr_ready) begin
        tr_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Event, enable and error state.
  // ----------------------------------------
  logic [NCH-1:0] chain;
  logic [NALL-1:0] acc_clr;

  assign chain = (cmpl_valid & cmpl_chain_en) ? (NCH'(1) << cmpl_code) : '0;
  assign acc_clr = acc ? (NALL'(1) << tr_chan) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evp_q <= '0;
      mset_q <= '0;
      qev_q <= '0;
    end else if (pce) begin
      evp_q <= (evp_q & ~event_clear_reg & ~used[NCH-1:0]) | ev_pulse;
      mset_q <= (mset_q & ~used[NCH-1:0]) | event_set_reg | chain;
      qev_q <= (qev_q & ~used[NALL-1:NCH]) | qtrig;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else if (pce) begin
      en_q[NCH-1:0] <= (en_q[NCH-1:0] | event_enable_set_reg) & ~event_enable_clear_reg;
      en_q[NALL-1:NCH] <= (en_q[NALL-1:NCH] | qesr) & ~qecr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emr_q <= '0;
      ser_q <= '0;
    end else if (pce) begin
      emr_q <= (emr_q & ~errclr) | (dead ? used : '0) |
               {2'b00, ev_pulse & evp_q & ~event_clear_reg};
      ser_q <= (ser_q & ~errclr & ~acc_clr) | used;
    end
  end

  // ----------------------------------------
  // Completion and interrupts.
  // ----------------------------------------
  logic [NCH-1:0] cset;

  assign cset = ((cmpl_valid & cmpl_int_en) ? (NCH'(1) << cmpl_code) : '0) | early_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipr_q <= '0;
      ier_q <= '0;
    end else if (pce) begin
      ipr_q <= (ipr_q & ~interrupt_clear_reg) | cset;
      ier_q <= (ier_q | interrupt_enable_set_reg) & ~iecr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpl_irq <= 1'b0;
      region_irq <= '0;
    end else if (pce) begin
      cmpl_irq <= |(ipr_q & ier_q);
      for (int r = 0; r < dceic_pkg::NRG; r++) begin
        region_irq[r] <= |(ipr_q & ier_q & region_channel_access_enable_q[r]);
      end
    end
  end

  // ----------------------------------------
  // Configuration registers.
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qsel_q <= '0;
      early_q <= '0;
      for (int i = 0; i < dceic_pkg::NQD; i++) begin
        map_set_q[i] <= '0;
        map_word_q[i] <= '0;
      end
      for (int i = 0; i < dceic_pkg::NRG; i++) begin
        region_channel_access_enable_q[i] <= '0;
        region_queued_access_enable_q[i] <= '0;
      end
    end else if (pce && wr) begin
      if (off == dceic_pkg::OFF_CH_QSEL) begin
        qsel_q[NCH-1:0] <= pwdata[NCH-1:0];
      end
      if (off == dceic_pkg::OFF_Q_QSEL) begin
        qsel_q[NALL-1:NCH] <= pwdata[dceic_pkg::NQD-1:0];
      end
      if (off == dceic_pkg::OFF_EARLY) begin
        early_q <= pwdata[NCH-1:0];
      end
      if (base8 == dceic_pkg::OFF_Q_MAP) begin
        map_set_q[off[dceic_pkg::IDX_BIT]] <= pwdata[dceic_pkg::QMAP_SET_LSB +: dceic_pkg::SETW];
        map_word_q[off[dceic_pkg::IDX_BIT]] <= pwdata[dceic_pkg::QMAP_WORD_LSB +: dceic_pkg::WORDW];
      end
      if (base8 == dceic_pkg::OFF_CH_ACC) begin
        region_channel_access_enable_q[off[dceic_pkg::IDX_BIT]] <= pwdata[NCH-1:0];
      end
      if (base8 == dceic_pkg::OFF_Q_ACC) begin
        region_queued_access_enable_q[off[dceic_pkg::IDX_BIT]] <= pwdata[dceic_pkg::NQD-1:0];
      end
    end
  end

  // ----------------------------------------
  // Read mux and bus answer.
  // ----------------------------------------
  always_comb begin
    rd_d = dceic_pkg::RST_VAL;
    bad = shadow & (off >= dceic_pkg::OFF_SHADOW_LIM);
    unique case (off)
      dceic_pkg::OFF_EVT_PEND: rd_d[NCH-1:0] = evp_q & mask[NCH-1:0];
      dceic_pkg::OFF_EVT_SET: rd_d[NCH-1:0] = mset_q & mask[NCH-1:0];
      dceic_pkg::OFF_EVT_EN: rd_d[NCH-1:0] = en_q[NCH-1:0] & mask[NCH-1:0];
      dceic_pkg::OFF_INT_PEND: rd_d[NCH-1:0] = ipr_q & mask[NCH-1:0];
      dceic_pkg::OFF_INT_EN: rd_d[NCH-1:0] = ier_q & mask[NCH-1:0];
      dceic_pkg::OFF_Q_EN: rd_d[dceic_pkg::NQD-1:0] = en_q[NALL-1:NCH] & mask[NALL-1:NCH];
      dceic_pkg::OFF_CH_QSEL: rd_d[NCH-1:0] = qsel_q[NCH-1:0];
      dceic_pkg::OFF_Q_QSEL: rd_d[dceic_pkg::NQD-1:0] = qsel_q[NALL-1:NCH];
      dceic_pkg::OFF_MISSED: rd_d[NALL-1:0] = emr_q;
      dceic_pkg::OFF_SECOND: rd_d[NALL-1:0] = ser_q;
      dceic_pkg::OFF_EARLY: rd_d[NCH-1:0] = early_q;
      dceic_pkg::OFF_CC_STAT: begin
        rd_d[QPW:0] = cnt[0];
        rd_d[dceic_pkg::CCST_Q1_LSB +: QPW+1] = cnt[1];
        rd_d[dceic_pkg::CCST_ACT_BIT] = (|ser_q) | tr_valid;
      end
      dceic_pkg::OFF_TU_STAT: rd_d[0] = tu_busy;
      dceic_pkg::OFF_EVT_CLR, dceic_pkg::OFF_EVT_EN_SET, dceic_pkg::OFF_EVT_EN_CLR,
      dceic_pkg::OFF_INT_CLR, dceic_pkg::OFF_INT_EN_SET, dceic_pkg::OFF_INT_EN_CLR,
      dceic_pkg::OFF_Q_EN_SET, dceic_pkg::OFF_Q_EN_CLR, dceic_pkg::OFF_ERR_CLR: rd_d = dceic_pkg::RST_VAL;
      default: begin
        if (base8 == dceic_pkg::OFF_Q_MAP) begin
          rd_d[dceic_pkg::QMAP_SET_LSB +: dceic_pkg::SETW] = map_set_q[off[dceic_pkg::IDX_BIT]];
          rd_d[dceic_pkg::QMAP_WORD_LSB +: dceic_pkg::WORDW] = map_word_q[off[dceic_pkg::IDX_BIT]];
        end else if (base8 == dceic_pkg::OFF_CH_ACC) begin
          rd_d[NCH-1:0] = region_channel_access_enable_q[off[dceic_pkg::IDX_BIT]];
        end else if (base8 == dceic_pkg::OFF_Q_ACC) begin
          rd_d[dceic_pkg::NQD-1:0] = region_queued_access_enable_q[off[dceic_pkg::IDX_BIT]];
        end else if (base32 == dceic_pkg::OFF_HIST) begin
          rd_d[CW-1:0] = qmem_q[off[dceic_pkg::HIST_Q_BIT]][off[3:2]];
        end else begin
          bad = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= dceic_pkg::RST_VAL;
      pslverr <= 1'b0;
    end else if (pce) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & bad;
      if (psel && !penable) begin
        prdata <= (pwrite || bad) ? dceic_pkg::RST_VAL : rd_d;
      end
    end
  end

endmodule : dceic_top
